// File: rtl/smi_pkg.sv
package smi_pkg;

	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam int          NUM_SMI_SRC     = 8;
	localparam int          NUM_EDGE_SRC    = 6;

	// Register offsets
	localparam logic [7:0]  OFS_SMI_SOURCE_ENABLE_SIX     = 8'h1B;
	localparam logic [7:0]  OFS_MISC_STS    = 8'h1C;
	localparam logic [7:0]  OFS_SER2_SHADOW = 8'h1D;

	// Reset values
	localparam logic [7:0]  RST_SMI_SOURCE_ENABLE_SIX     = 8'h00;
	localparam logic [5:0]  RST_MISC_STS    = 6'h00;
	localparam logic [7:0]  RST_SER2_SHADOW = 8'h00;
	localparam logic [7:0]  READ_UNMAPPED   = 8'h00;
	localparam logic [1:0]  MISC_RSVD_VAL   = 2'h0;
	localparam logic [1:0]  SHADOW_RSVD_VAL = 2'h0;

	// Shadow field positions
	localparam int          SH_FIFO_EN      = 0;
	localparam int          SH_RX_CLR       = 1;
	localparam int          SH_TX_CLR       = 2;
	localparam int          SH_DMA_MODE     = 3;
	localparam int          SH_RSVD_LO      = 4;
	localparam int          SH_RSVD_HI      = 5;
	localparam int          SH_THR_LSB      = 6;
	localparam int          SH_THR_MSB      = 7;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} smi_req_t;

	// Edge inputs in status bit order 5..0
	typedef struct packed {
		logic gpioPort6In1;
		logic gpioPort6In0;
		logic gpioPort4In3;
		logic gpioPort4In1;
		logic gpioPort2In2;
		logic gpioPort2In1;
	} smi_edge_in_t;

	// Mirrored serial port FIFO control write
	typedef struct packed {
		logic       wr;
		logic [1:0] receiveFillThreshold;
		logic       dmaModeSelect;
		logic       transmitFifoClear;
		logic       receiveFifoClear;
		logic       fifoEnable;
	} smi_fcr_t;

endpackage

// File: rtl/smi_regs.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps

module smi_regs (
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic                       hostRst,
	input  wire smi_pkg::smi_req_t          req,
	output logic [smi_pkg::DATA_W-1:0]      rdata,
	input  wire logic [smi_pkg::NUM_SMI_SRC-1:0] gpioPort1Event,
	input  wire smi_pkg::smi_edge_in_t      edgeIn,
	input  wire smi_pkg::smi_fcr_t          serial2Fcr,
	output logic [smi_pkg::NUM_SMI_SRC-1:0] smiStatusBus,
	output logic [smi_pkg::NUM_EDGE_SRC-1:0] edgeEventStatus
);
	import smi_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0]       smiSourceEnableSix;
		logic [NUM_EDGE_SRC-1:0] miscEdgeEventStatus;
		logic [DATA_W-1:0]       serial2FifoControlShadow;
		logic [NUM_EDGE_SRC-1:0] sync1;
		logic [NUM_EDGE_SRC-1:0] sync2;
		logic [NUM_EDGE_SRC-1:0] sync3;
		logic [NUM_SMI_SRC-1:0]  smiBus;
		logic [DATA_W-1:0]       rdata;
	} smi_state_t;

	smi_state_t state;
	smi_state_t next_state;

	function automatic logic hit(input smi_req_t r, input logic [7:0] ofs);
		hit = (r.addr == ofs);
	endfunction

	logic [NUM_EDGE_SRC-1:0] edgeSeen;
	logic [NUM_EDGE_SRC-1:0] clearMask;
	logic [DATA_W-1:0]       fcrImage;

	// Compare stages two and three only; stage one feeds stage two alone
	genvar g;
	generate
		for (g = 0; g < NUM_EDGE_SRC; g++) begin : gEdge
			assign edgeSeen[g] = state.sync2[g] ^ state.sync3[g];
		end
	endgenerate

	always_comb begin
		clearMask = '0;
		if (req.wr && hit(req, OFS_MISC_STS))
			clearMask = req.wdata[NUM_EDGE_SRC-1:0];
	end

	always_comb begin
		fcrImage                 = '0;
		fcrImage[SH_FIFO_EN]     = serial2Fcr.fifoEnable;
		fcrImage[SH_RX_CLR]      = serial2Fcr.receiveFifoClear;
		fcrImage[SH_TX_CLR]      = serial2Fcr.transmitFifoClear;
		fcrImage[SH_DMA_MODE]    = serial2Fcr.dmaModeSelect;
		fcrImage[SH_RSVD_HI:SH_RSVD_LO] = SHADOW_RSVD_VAL;
		fcrImage[SH_THR_MSB:SH_THR_LSB] =
			serial2Fcr.receiveFillThreshold;
	end

	always_comb begin
		next_state       = state;
		next_state.sync1 = edgeIn;
		next_state.sync2 = state.sync1;
		next_state.sync3 = state.sync2;
		// Set beats clear so an edge in the clearing cycle is kept
		next_state.miscEdgeEventStatus =
			(state.miscEdgeEventStatus & ~clearMask) | edgeSeen;
		if (req.wr && hit(req, OFS_SMI_SOURCE_ENABLE_SIX))
			next_state.smiSourceEnableSix = req.wdata;
		// Bit g of enable gates port-one input g
		next_state.smiBus =
			gpioPort1Event & state.smiSourceEnableSix;
		// Own address writes fall through: read only
		if (serial2Fcr.wr)
			next_state.serial2FifoControlShadow = fcrImage;
		next_state.rdata = READ_UNMAPPED;
		if (req.rd) begin
			case (req.addr)
				OFS_SMI_SOURCE_ENABLE_SIX:     next_state.rdata = state.smiSourceEnableSix;
				OFS_MISC_STS:    next_state.rdata =
					{MISC_RSVD_VAL, state.miscEdgeEventStatus};
				OFS_SER2_SHADOW: next_state.rdata =
					state.serial2FifoControlShadow;
				default:         next_state.rdata = READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state.smiSourceEnableSix       <= RST_SMI_SOURCE_ENABLE_SIX;
			state.miscEdgeEventStatus      <= RST_MISC_STS;
			state.serial2FifoControlShadow <= RST_SER2_SHADOW;
			state.sync1                    <= '0;
			state.sync2                    <= '0;
			state.sync3                    <= '0;
			state.smiBus                   <= '0;
			state.rdata                    <= READ_UNMAPPED;
		end else begin
			state <= next_state;
			// Main power and hard reset clear only the shadow
			if (hostRst)
				state.serial2FifoControlShadow <= RST_SER2_SHADOW;
		end
	end

	assign rdata           = state.rdata;
	assign smiStatusBus    = state.smiBus;
	assign edgeEventStatus = state.miscEdgeEventStatus;

endmodule

// File: test/smi_regs_sva.sv
`timescale 1ns/1ps
module smi_regs_sva (
	input wire logic mclk, rst,
	input wire smi_pkg::smi_req_t req,
	input wire smi_pkg::smi_edge_in_t edgeIn,
	input wire logic [7:0] rdata, gpioPort1Event, smiStatusBus,
	input wire logic [5:0] edgeEventStatus
);
	import smi_pkg::*;
	wire wrEn = req.wr && req.addr == 8'h1B;
	wire [5:0] clr = req.wr && req.addr == 8'h1C ? req.wdata[5:0] : 6'h00;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	a_bus_on: assert property (wrEn ##1 !wrEn |=> smiStatusBus ==
		($past(gpioPort1Event) & $past(req.wdata, 2))) else $error("bus");
	a_bus_off: assert property ((smiStatusBus & ~$past(gpioPort1Event))
		== 8'h00) else $error("bus");
	a_bus_hold: assert property (!wrEn ##1 $stable(gpioPort1Event) |=>
		$stable(smiStatusBus)) else $error("bus");
	a_sts_rd: assert property (req.rd && req.addr == 8'h1C |=>
		rdata == {2'h0, $past(edgeEventStatus)}) else $error("status");
	a_sts_hold: assert property (($past(edgeEventStatus) & ~$past(clr)
		& ~edgeEventStatus) == 6'h00) else $error("status");
	a_sts_clr: assert property ($stable(edgeIn)[*5] ##0 clr != 6'h00 |=>
		(edgeEventStatus & $past(clr)) == 6'h00) else $error("clear");
	a_unmapped: assert property (req.rd && (req.addr < 8'h1B ||
		req.addr > 8'h1D) |=> rdata == 8'h00) else $error("unmapped");
	a_rd_idle: assert property (!req.rd |=> rdata == 8'h00) else $error("idle");
	cover property (wrEn);
	cover property (clr != 6'h00);
	cover property (req.rd && req.addr == 8'h1D);
endmodule
bind smi_regs smi_regs_sva i_sva (.mclk, .rst, .req, .edgeIn, .rdata,
	.gpioPort1Event, .smiStatusBus, .edgeEventStatus);

// File: test/smi_pin_model.sv
`timescale 1ns/1ps
module smi_pin_model (
	input  wire logic             mclk,
	output smi_pkg::smi_edge_in_t edgeIn = '0,
	output logic [7:0]            gpioPort1Event = 8'h00
);
	// Driven on the edge; the design still treats edgeIn as asynchronous, but registers gpioPort1Event directly
	task toggle(int b);
		@(posedge mclk) edgeIn[b] <= ~edgeIn[b];
	endtask
	task events(logic [7:0] v);
		@(posedge mclk) gpioPort1Event <= v;
	endtask
endmodule

// File: test/test_smi_regs.sv
`timescale 1ns/1ps
module test_smi_regs;
	import smi_pkg::*;
	logic         mclk = 0, rst = 1, hostRst = 0;
	smi_req_t     req = '0;
	smi_fcr_t     fcr = '0;
	smi_edge_in_t pin;
	logic [7:0]   rdata, ev, bus;
	logic [5:0]   sts;
	int           errorCnt = 0, totalChecks = 0;
	always #2 mclk = ~mclk;
	smi_pin_model i_pins (.mclk, .edgeIn(pin), .gpioPort1Event(ev));
	smi_regs i_dut (.mclk, .rst, .hostRst, .req, .rdata, .gpioPort1Event(ev),
		.edgeIn(pin), .serial2Fcr(fcr), .smiStatusBus(bus),
		.edgeEventStatus(sts));
	task chk(string n, logic [7:0] e, s);
		totalChecks++;
		if (s !== e) begin
			errorCnt++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(logic [7:0] a, d);
		@(posedge mclk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk) req.wr <= 1'b0;
	endtask
	task rd(logic [7:0] a, e);
		@(posedge mclk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk) req.rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	task results;
		$display("checks %0d errors %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#20000 errorCnt++;
		results();
	end
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		for (int a = 8'h1A; a < 8'h1F; a++) rd(8'(a), 8'h00);
		i_pins.events(8'hFF);
		for (int i = 0; i < 8; i++) begin
			wr(8'h1B, 8'h01 << i);
			@(posedge mclk) #1 chk("bus", 8'h01 << i, bus);
		end
		i_pins.events(8'h5A);
		wr(8'h1B, 8'h0F);
		@(posedge mclk) #1 chk("bus", 8'h0A, bus);
		for (int k = 0; k < 12; k++) begin
			i_pins.toggle(k % 6);
			repeat (6) @(posedge mclk);
			rd(8'h1C, 8'h3F >> (5 - k % 6));
			chk("status", 8'h3F >> (5 - k % 6), {2'b00, sts});
			if (k == 5) wr(8'h1C, 8'hFF);
		end
		@(posedge mclk) fcr <= '{1'b1, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1};
		@(posedge mclk) fcr.wr <= 1'b0;
		wr(8'h1D, 8'h00);
		rd(8'h1D, 8'h8B);
		@(posedge mclk) hostRst <= 1'b1;
		rd(8'h1D, 8'h00);
		hostRst <= 1'b0;
		rd(8'h1B, 8'h0F);
		// Second reset in mid-run returns every register to its default
		@(posedge mclk) rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd(8'h1B, 8'h00);
		chk("bus", 8'h00, bus);
		chk("status", 8'h00, {2'b00, sts});
		results();
	end
endmodule
